// ===== ptr_unit_params.svh
// Constants and register offsets for the indirect address pointer unit
`ifndef PTR_UNIT_PARAMS_SVH
`define PTR_UNIT_PARAMS_SVH

`define PTR_W          12
`define PTR_NUM        3
`define PTR_HI_USED    4
`define PTR_ONE        12'h001
`define PTR_RESET      12'h000
// Register word offsets (byte addresses), chosen for this block
`define OFS_LOW0       8'h00
`define OFS_HIGH0      8'h04
`define OFS_LOW1       8'h08
`define OFS_HIGH1      8'h0C
`define OFS_LOW2       8'h10
`define OFS_HIGH2      8'h14
`define OFS_STAT       8'h18
`define REG_STRIDE     8
`define HI_ZERO        4'h0

`endif

// ===== ptr_unit_pkg.sv
// Types for the indirect address pointer unit
`default_nettype none
package ptr_unit_pkg;
    // Operand kinds per pointer pair
    typedef enum logic [2:0] {
        OP_PLAIN,
        OP_AFTER_ACCESS_INCREMENT_OPERAND,
        OP_AFTER_ACCESS_DECREMENT_OPERAND,
        OP_BEFORE_ACCESS_INCREMENT_OPERAND,
        OP_PLUSACC
    } op_kind_t;
endpackage : ptr_unit_pkg
`default_nettype wire

// ===== ptr_addr_calc.sv
// Address and next-pointer calculation for one operand access
`include "ptr_unit_params.svh"
`default_nettype none
module ptr_addr_calc
    import ptr_unit_pkg::*;
(
    input  wire logic [`PTR_W-1:0] ptr_i,
    input  wire op_kind_t          kind_i,
    input  wire logic [7:0]        acc_i,
    output logic      [`PTR_W-1:0] addr_o,
    output logic      [`PTR_W-1:0] ptr_next_o
);
    logic [`PTR_W-1:0] ofs;

    // Sign-extended accumulator offset
    assign ofs = {{(`PTR_W-8){acc_i[7]}}, acc_i};

    // Address and updated pointer, all sums wrap in 12 bits
    always_comb begin
        addr_o     = ptr_i;
        ptr_next_o = ptr_i;
        case (kind_i)
            OP_AFTER_ACCESS_INCREMENT_OPERAND: ptr_next_o = ptr_i + `PTR_ONE;
            OP_AFTER_ACCESS_DECREMENT_OPERAND: ptr_next_o = ptr_i - `PTR_ONE;
            OP_BEFORE_ACCESS_INCREMENT_OPERAND: begin
                ptr_next_o = ptr_i + `PTR_ONE;
                addr_o     = ptr_i + `PTR_ONE;
            end
            OP_PLUSACC: addr_o = ptr_i + ofs;
            default: addr_o = ptr_i;
        endcase
    end
endmodule : ptr_addr_calc
`default_nettype wire

// ===== ptr_unit.sv
// Indirect pointer unit: three pointer pairs, operand access port, Wishbone registers
`include "ptr_unit_params.svh"
`default_nettype none
module ptr_unit
    import ptr_unit_pkg::*;
#(
    parameter int NPTR = `PTR_NUM
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone classic slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [7:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // Core operand access
    input  wire logic              op_req_i,
    input  wire logic [1:0]        op_sel_i,
    input  wire op_kind_t          op_kind_i,
    input  wire logic              op_we_i,
    input  wire logic [7:0]        op_wdata_i,
    input  wire logic [7:0]        acc_i,
    input  wire logic [7:0]        bank_sel_i,
    input  wire logic              access_bank_i,
    output logic                   op_done_o,
    output logic      [7:0]        op_rdata_o,
    // Data memory
    output logic                   mem_req_o,
    output logic                   mem_we_o,
    output logic      [`PTR_W-1:0] mem_addr_o,
    output logic      [7:0]        mem_wdata_o,
    input  wire logic [7:0]        mem_rdata_i
);
    // Whole module state
    typedef struct packed {
        logic [2:0][`PTR_W-1:0] ptr;
        logic [31:0]            dat;
        logic                   ack;
        logic                   busy;
        logic                   wr;
        logic [`PTR_W-1:0]      addr;
        logic [7:0]             wdata;
        logic [7:0]             rdata;
        logic                   done;
        logic [1:0]             last_sel;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [`PTR_W-1:0] calc_ptr;
    logic [`PTR_W-1:0] calc_addr;
    logic [`PTR_W-1:0] calc_next;
    logic              bus_go;
    logic              op_go;

    // Selected pointer for the incoming operand
    assign calc_ptr = st_r.ptr[op_sel_i];
    assign bus_go   = cyc_i && stb_i && !st_r.ack;
    // Bus writes and operand accesses are not taken together; bus waits
    assign op_go    = op_req_i && !st_r.busy && (op_sel_i < 2'(NPTR));

    ptr_addr_calc u_calc (
        .ptr_i      (calc_ptr),
        .kind_i     (op_kind_i),
        .acc_i      (acc_i),
        .addr_o     (calc_addr),
        .ptr_next_o (calc_next)
    );

    // Next-state logic
    always_comb begin
        st_nxt      = st_r;
        st_nxt.ack  = 1'b0;
        st_nxt.done = 1'b0;
        // Operand access phase two: memory answered, return read data
        if (st_r.busy) begin
            st_nxt.busy  = 1'b0;
            st_nxt.done  = 1'b1;
            st_nxt.rdata = st_r.wr ? st_r.rdata : mem_rdata_i;
        end
        // Operand access phase one: bank inputs never used here
        if (op_go) begin
            st_nxt.busy     = 1'b1;
            st_nxt.wr       = op_we_i;
            st_nxt.addr     = calc_addr;
            st_nxt.wdata    = op_wdata_i;
            st_nxt.last_sel = op_sel_i;
            st_nxt.ptr[op_sel_i] = calc_next;
        end else if (bus_go) begin
            st_nxt.ack = 1'b1;
            st_nxt.dat = 32'h0000_0000;
            case (adr_i)
                `OFS_LOW0, `OFS_LOW1, `OFS_LOW2: begin
                    st_nxt.dat[7:0] = st_r.ptr[adr_i / `REG_STRIDE][7:0];
                    if (we_i && sel_i[0])
                        st_nxt.ptr[adr_i / `REG_STRIDE][7:0] = dat_i[7:0];
                end
                `OFS_HIGH0, `OFS_HIGH1, `OFS_HIGH2: begin
                    st_nxt.dat[7:0] = {`HI_ZERO,
                        st_r.ptr[adr_i / `REG_STRIDE][`PTR_W-1:8]};
                    if (we_i && sel_i[0])
                        st_nxt.ptr[adr_i / `REG_STRIDE][`PTR_W-1:8] =
                            dat_i[`PTR_HI_USED-1:0];
                end
                `OFS_STAT: st_nxt.dat[`PTR_W+2:0] = {st_r.last_sel, st_r.busy, st_r.addr};
                default: st_nxt.dat = 32'h0000_0000;
            endcase
        end
        if (rst_i) begin
            st_nxt     = '0;
            st_nxt.ptr = {3{`PTR_RESET}};
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

    // Outputs
    assign dat_o       = st_r.dat;
    assign ack_o       = st_r.ack;
    assign op_done_o   = st_r.done;
    assign op_rdata_o  = st_r.rdata;
    assign mem_req_o   = st_r.busy;
    assign mem_we_o    = st_r.busy && st_r.wr;
    assign mem_addr_o  = st_r.addr;
    assign mem_wdata_o = st_r.wdata;

    // Helper: pointer value before an operand
    logic [`PTR_W-1:0] pre_ptr;
    assign pre_ptr = st_r.ptr[op_sel_i];

    AST_AFTER_ACCESS_INCREMENT_OPERAND: assert property (@(posedge clk_i) disable iff (rst_i)
        op_go && op_kind_i == OP_AFTER_ACCESS_INCREMENT_OPERAND |=> mem_addr_o == $past(pre_ptr)
            && st_r.ptr[st_r.last_sel] == 12'($past(pre_ptr) + `PTR_ONE))
        else $error("post-increment wrong");
    AST_AFTER_ACCESS_DECREMENT_OPERAND: assert property (@(posedge clk_i) disable iff (rst_i)
        op_go && op_kind_i == OP_AFTER_ACCESS_DECREMENT_OPERAND |=> mem_addr_o == $past(pre_ptr)
            && st_r.ptr[st_r.last_sel] == 12'($past(pre_ptr) - `PTR_ONE))
        else $error("post-decrement wrong");
    AST_BEFORE_ACCESS_INCREMENT_OPERAND: assert property (@(posedge clk_i) disable iff (rst_i)
        op_go && op_kind_i == OP_BEFORE_ACCESS_INCREMENT_OPERAND |=> mem_addr_o == 12'($past(pre_ptr) + `PTR_ONE))
        else $error("pre-increment address wrong");
    AST_PLAIN: assert property (@(posedge clk_i) disable iff (rst_i)
        op_go && op_kind_i == OP_PLAIN |=> mem_addr_o == $past(pre_ptr)
            && st_r.ptr[st_r.last_sel] == $past(pre_ptr))
        else $error("plain access moved pointer");
    AST_PLUSACC: assert property (@(posedge clk_i) disable iff (rst_i)
        op_go && op_kind_i == OP_PLUSACC |=> mem_addr_o ==
            12'($past(pre_ptr) + {{4{$past(acc_i[7])}}, $past(acc_i)}))
        else $error("offset address wrong");
    AST_PLUSKEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        op_go && op_kind_i == OP_PLUSACC |=> st_r.ptr[st_r.last_sel] == $past(pre_ptr))
        else $error("offset access moved pointer");
    AST_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
        op_go |=> mem_req_o ##1 op_done_o && !mem_req_o)
        else $error("operand access timing wrong");
    AST_HIZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(adr_i) == `OFS_HIGH1 |-> dat_o[7:`PTR_HI_USED] == `HI_ZERO)
        else $error("unused high bits not zero");
    AST_BANK: assert property (@(posedge clk_i) disable iff (rst_i)
        op_go && op_kind_i == OP_PLAIN && $changed(bank_sel_i) |=> mem_addr_o == $past(pre_ptr))
        else $error("bank select affected address");

    COV_AFTER_ACCESS_INCREMENT_OPERAND: cover property (@(posedge clk_i) op_go && op_kind_i == OP_AFTER_ACCESS_INCREMENT_OPERAND);
    COV_PLUSACC: cover property (@(posedge clk_i) op_go && op_kind_i == OP_PLUSACC);
    COV_BUSWR:   cover property (@(posedge clk_i) bus_go && we_i);
    COV_WRAP:    cover property (@(posedge clk_i) op_go && op_kind_i == OP_AFTER_ACCESS_DECREMENT_OPERAND
                     && pre_ptr == `PTR_RESET);
endmodule : ptr_unit
`default_nettype wire

// ===== data_mem_model.sv
// Data memory model that answers the pointer unit within the same cycle
`default_nettype none
module data_mem_model (
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [4096];
    // Seeded contents: low address byte XORed with the high address nibble in both halves
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i) ^ {4'(i >> 8), 4'(i >> 8)};
        end
    end
    // Outside an access the data lines show the inverse, never a stale match
    assign rdata_o = req_i ? mem[addr_i] : ~mem[addr_i];
    // Writes land at the edge that samples the request
    always @(posedge clk_i) begin
        if (req_i && we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end
endmodule : data_mem_model
`default_nettype wire

// ===== ptr_unit_tb_top.sv
// Self-checking bench for the indirect pointer unit
`default_nettype none
module ptr_unit_tb_top import ptr_unit_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, op_req_i, op_we_i;
    logic        access_bank_i, op_done_o, mem_req_o, mem_we_o;
    logic [7:0]  adr_i, op_wdata_i, acc_i, bank_sel_i, op_rdata_o, mem_wdata_o, mem_rdata_i;
    logic [3:0]  sel_i;
    logic [1:0]  op_sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [11:0] mem_addr_o, p, ea;
    op_kind_t    op_kind_i;
    int          mismatches = 0;
    int          samples_checked = 0;
    logic [11:0] bases [3] = '{12'hFFF, 12'h000, 12'h7F0};
    logic [7:0]  accs [3] = '{8'h7F, 8'h80, 8'hFF};

    ptr_unit dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .op_req_i(op_req_i), .op_sel_i(op_sel_i), .op_kind_i(op_kind_i), .op_we_i(op_we_i),
        .op_wdata_i(op_wdata_i), .acc_i(acc_i), .bank_sel_i(bank_sel_i),
        .access_bank_i(access_bank_i), .op_done_o(op_done_o), .op_rdata_o(op_rdata_o),
        .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));
    data_mem_model mem (.clk_i(clk_i), .req_i(mem_req_o), .we_i(mem_we_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

    // 10 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    function automatic logic [7:0] memv(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], a[11:8]};
    endfunction : memv

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One classic cycle; waits for ack, then idles a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        chk(32'(ack_o), 32'h1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic setp(input int n, input logic [11:0] v);
        wb(1'b1, 8'(n * 8), {24'h0, v[7:0]});
        wb(1'b1, 8'(n * 8 + 4), {24'h0, 4'hF, v[11:8]});
    endtask : setp

    task automatic chkp(input int n, input logic [11:0] v);
        wb(1'b0, 8'(n * 8), 32'h0);
        chk(rd, {24'h0, v[7:0]});
        wb(1'b0, 8'(n * 8 + 4), 32'h0);
        chk(rd, {28'h0, v[11:8]});
    endtask : chkp

    // Operand access: address and direction in cycle 1, result in cycle 2
    task automatic op(input int n, input op_kind_t k, input logic w, input logic [11:0] a,
                      input logic [7:0] d);
        int c;
        c = 0;
        op_req_i <= 1'b1;
        op_sel_i <= 2'(n);
        op_kind_i <= k;
        op_we_i <= w;
        bank_sel_i <= ~bank_sel_i;
        access_bank_i <= ~access_bank_i;
        @(posedge clk_i);
        op_req_i <= 1'b0;
        do begin
            @(posedge clk_i);
            c++;
        end while (mem_req_o !== 1'b1 && c < 20);
        chk(32'(mem_req_o), 32'h1);
        chk(32'(mem_addr_o), 32'(a));
        chk(32'(mem_we_o), 32'(w));
        if (w) chk(32'(mem_wdata_o), 32'(d));
        @(posedge clk_i);
        chk(32'(op_done_o), 32'h1);
        if (!w) chk(32'(op_rdata_o), 32'(d));
    endtask : op

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    // Watchdog against a hung handshake
    initial begin
        #1000000;
        mismatches++;
        final_report();
    end

    initial begin
        {cyc_i, stb_i, we_i, op_req_i, op_we_i, access_bank_i} = '0;
        {adr_i, dat_i, op_sel_i, op_wdata_i, acc_i, bank_sel_i} = '0;
        sel_i = 4'h1;
        op_kind_i = OP_PLAIN;
        rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int n = 0; n < 3; n++) chkp(n, 12'h000);
        wb(1'b1, 8'h1C, 32'hFF);
        wb(1'b0, 8'h1C, 32'h0);
        chk(rd, 32'h0);
        $display("test reset and unmapped done");
        // Every operand kind on every pointer, bank inputs varied, wrap both ways
        for (int n = 0; n < 3; n++) begin
            p = bases[n];
            acc_i <= accs[n];
            bank_sel_i <= 8'(n * 85);
            access_bank_i <= ~access_bank_i;
            setp(n, p);
            op(n, OP_PLAIN, 1'b0, p, memv(p));
            chkp(n, p);
            op(n, OP_AFTER_ACCESS_INCREMENT_OPERAND, 1'b0, p, memv(p));
            p = p + 12'h001;
            chkp(n, p);
            op(n, OP_AFTER_ACCESS_DECREMENT_OPERAND, 1'b0, p, memv(p));
            p = p - 12'h001;
            chkp(n, p);
            p = p + 12'h001;
            op(n, OP_BEFORE_ACCESS_INCREMENT_OPERAND, 1'b0, p, memv(p));
            chkp(n, p);
            ea = p + {{4{accs[n][7]}}, accs[n]};
            op(n, OP_PLUSACC, 1'b0, ea, memv(ea));
            chkp(n, p);
        end
        $display("test operand kinds done");
        op_wdata_i <= 8'h3C;
        op(2, OP_PLAIN, 1'b1, p, 8'h3C);
        op(2, OP_AFTER_ACCESS_INCREMENT_OPERAND, 1'b0, p, 8'h3C);
        wb(1'b0, 8'h18, 32'h0);
        chk(rd, {17'h0, 2'd2, 1'b0, p});
        $display("test write through operand done");
        final_report();
    end
endmodule : ptr_unit_tb_top
`default_nettype wire
